// ---- shared/sperr_pkg.sv ----
`default_nettype none
package sperr_pkg;
  // wishbone word offsets (byte addresses)
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  // control field positions
  localparam int CTRL_SEL = 0;
  localparam int CTRL_VAL = 1;
  localparam int CTRL_LIM = 2;
  localparam logic [2:0] CTRL_RESET = 3'h2;
  // status field positions
  localparam int STAT_ERR = 0;
  localparam int STAT_LOCK = 1;
  localparam int STAT_NPCM = 2;
  localparam int STAT_EMPH = 3;
  localparam int STAT_OSC = 4;
  localparam int STAT_RUN = 8;
  // parity run limits
  localparam logic [3:0] RUN_LONG = 4'h9;
  localparam logic [3:0] RUN_SHORT = 4'h8;
  // hold window in ms and its default length in frames at 48 kHz (32 ms)
  localparam int HOLD_MS_MIN = 15;
  localparam int HOLD_MS_MAX = 50;
  localparam int HOLD_FRAMES = 1536;
  // clock and oscillator word clock
  localparam int CLK_MHZ = 100;
  localparam int OSC_WORD_KHZ = 48;
  localparam int OSC_DIV = (CLK_MHZ * 1000) / OSC_WORD_KHZ;
  localparam int UNLOCK_WORDS = 16;
  localparam int PRE_TIMEOUT = 2048;
  localparam int CS_BITS = 192;
endpackage
`default_nettype wire

// ---- src/sperr_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RQ1: error output goes high on lock loss or data stream errors.
// RQ2: modulation violation or missing preambles means unlocked.
// RQ3: after lock error, error stays high a 15-50 ms hold once valid.
// RQ4: error output changes only on frame clock ticks.
// RQ5: each subframe parity is checked; failures are parity errors.
// RQ6: nine or more consecutive parity errors raise error with the hold.
// RQ7: short runs pulse error for non-PCM only, not for PCM.
// RQ8: sampling-frequency status bits changing between blocks raises error.
// RQ9: with range limiting, fs calculation mismatch raises error.
// RQ10: short PCM parity runs repeat the previous same-channel sample.
// RQ11: short non-PCM runs pass data; non-PCM taken before errors.
// RQ12: audio output is held low on lock error or long parity run.
// RQ13: short runs output channel status bits from previous block.
// RQ14: lock error or long run forces fs, status and sub-code low.
// RQ15: locked state entered once B, M and W preambles all seen.
// RQ16: audio restarts at first frame tick after error falls.
// RQ17: non-PCM pin follows status bit 1.
// RQ18: emphasis pin high for 50/15 us pre-emphasis, low otherwise.
// RQ19: user output selects register bit or transition; bit resets to 1.
// RQ20: transition mode holds output high, pulses low on clock switch.
// RQ21: lock-in pulse starts on oscillator word tick, ends as error falls.
// RQ22: unlock pulse starts as error rises, ends after word count.
// RQ23: fs outside reception range is an error, clocks go to oscillator; the code flags out of range only with range limiting (CTRL_LIM) set.
// RQ24: hold and unlock count are frame/word counters set by parameters.
// RQ25: parity run counter clears on every good-parity subframe.
module sperr_top #(
  parameter int HOLD_LEN = sperr_pkg::HOLD_FRAMES,
  parameter int OSC_DIV = sperr_pkg::OSC_DIV,
  parameter int UNLOCK_LEN = sperr_pkg::UNLOCK_WORDS,
  parameter int PRE_GAP = sperr_pkg::PRE_TIMEOUT
) (
  input wire logic clk_i, // 100 MHz
  input wire logic rst_i, // sync, high
  input wire logic [3:0] wb_adr_i, // byte address
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic wb_we_i, // write
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // ack
  input wire logic frame_clock_i, // frame tick pulse
  input wire logic bmc_viol_i, // modulation violation
  input wire logic pre_b_i, // preamble b seen
  input wire logic pre_m_i, // preamble m seen
  input wire logic pre_w_i, // preamble w seen
  input wire logic sub_valid_i, // subframe strobe
  input wire logic sub_right_i, // subframe is right
  input wire logic sub_parity_i, // parity bit received
  input wire logic [27:0] sub_bits_i, // bits covered by parity
  input wire logic [7:0] cs_idx_i, // status bit index
  input wire logic cs_block_i, // block end strobe
  input wire logic [3:0] cs_fs_i, // status bits 24..27
  input wire logic cs_npcm_i, // status bit 1
  input wire logic cs_emph_i, // status emphasis
  input wire logic fs_valid_i, // fs calc strobe
  input wire logic [3:0] fs_calc_i, // fs calc result
  input wire logic fs_in_range_i, // fs inside range
  output logic error_o, // error flag
  output logic locked_o, // lock state
  output logic [23:0] audio_data_out_o, // audio sample
  output logic audio_valid_o, // sample strobe
  output logic audio_right_o, // sample channel
  output logic cs_bit_o, // status bit out
  output logic [3:0] fs_out_o, // fs result out
  output logic subq_en_o, // sub-code enable
  output logic npcm_o, // non-pcm pin
  output logic emph_o, // emphasis pin
  output logic osc_src_o, // clocks from oscillator
  output logic user_port_out_o // user pin
);
  typedef enum logic [3:0] {
    SP_IDLE = 4'b0001,
    SP_WAIT = 4'b0010,
    SP_IN = 4'b0100,
    SP_OUT = 4'b1000
  } sperr_tp_t;

  sperr_tp_t tp_reg, tp_next;
  logic [2:0] ctrl_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic lock_reg, err_reg, short_reg, outen_reg;
  logic [2:0] seen_reg;
  logic [3:0] run_reg, run_next;
  logic [15:0] hold_reg;
  logic [15:0] gap_reg;
  logic [15:0] div_reg;
  logic [15:0] word_reg;
  logic [3:0] csfs_reg, fsprev_reg, fsout_reg;
  logic npcm_reg, npcm_lat, emph_reg, upo_reg, csb_reg, subq_reg;
  logic [23:0] prev_l, prev_r, aud_reg;
  logic aval_reg, aright_reg;
  logic cs_mem [0:sperr_pkg::CS_BITS-1];

  function automatic logic odd_parity(input logic [27:0] b, input logic p);
    return ^{b, p};
  endfunction

  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire ctrl_hit = wb_adr_i == sperr_pkg::ADDR_CTRL;
  wire stat_hit = wb_adr_i == sperr_pkg::ADDR_STAT;
  wire ctrl_wr = bus_req & wb_we_i & ctrl_hit & wb_sel_i[0];
  wire sel_tp = ctrl_reg[sperr_pkg::CTRL_SEL];
  wire lim_en = ctrl_reg[sperr_pkg::CTRL_LIM];
  wire osc_tick = div_reg == 16'(OSC_DIV - 1);
  wire par_err = sub_valid_i & odd_parity(sub_bits_i, sub_parity_i); // see RQ5
  wire gap_out = gap_reg >= 16'(PRE_GAP);
  wire lose_lock = lock_reg & (bmc_viol_i | gap_out); // see RQ2
  wire all_seen = &seen_reg; // see RQ15
  wire run_long = run_reg >= sperr_pkg::RUN_LONG;
  // the ninth bad subframe itself already belongs to the long run
  wire run_hit = par_err & (run_reg >= sperr_pkg::RUN_SHORT); // see RQ12
  wire out_rng = lim_en & fs_valid_i & ~fs_in_range_i; // see RQ23
  wire cs_chg = lock_reg & cs_block_i & (cs_fs_i != csfs_reg); // see RQ8
  wire fs_chg = lim_en & fs_valid_i & (fs_calc_i != fsprev_reg); // see RQ9
  wire hard_err = ~lock_reg | run_long; // see RQ1
  wire cause = hard_err | out_rng | cs_chg | fs_chg;
  wire err_next = hard_err | (hold_reg != 16'h0) | short_reg; // see RQ3
  wire err_rise = frame_clock_i & ~err_reg & err_next;
  wire err_fall = frame_clock_i & err_reg & ~err_next;
  wire mute = hard_err | run_hit | ~outen_reg; // see RQ12
  wire repeat_pcm = par_err & ~npcm_lat & ~run_hit & ~run_long; // see RQ10
  wire [23:0] prev_same = sub_right_i ? prev_r : prev_l;
  wire [23:0] aud_next = mute ? 24'h0 : (repeat_pcm ? prev_same : sub_bits_i[23:0]);
  wire cs_in = sub_bits_i[26];
  wire cs_next = (hard_err | run_hit) ? 1'b0 : (par_err ? cs_mem[cs_idx_i] : cs_in); // see RQ13
  wire [31:0] stat_word = {20'h0, run_reg, 3'h0, osc_src_o, emph_reg, npcm_reg,
                           lock_reg, err_reg};
  wire [31:0] rd_word = ctrl_hit ? {29'h0, ctrl_reg} : (stat_hit ? stat_word : 32'h0);

  // parity run saturates at the long limit
  always_comb begin
    run_next = run_reg;
    if (sub_valid_i) begin
      if (!par_err) begin
        run_next = 4'h0; // see RQ25
      end else if (!run_long) begin
        run_next = run_reg + 4'h1;
      end
    end
  end

  always_comb begin
    tp_next = tp_reg;
    unique case (tp_reg)
      SP_IDLE: begin
        // lock may come back while the unlock pulse runs, so wait on lock with error high
        if (err_rise) begin
          tp_next = SP_OUT; // see RQ22
        end else if (lock_reg & err_reg) begin
          tp_next = SP_WAIT;
        end
      end
      SP_WAIT: begin
        if (osc_tick) begin
          tp_next = SP_IN; // see RQ21
        end
      end
      SP_IN: begin
        if (err_fall) begin
          tp_next = SP_IDLE; // see RQ21
        end else if (~lock_reg) begin
          tp_next = SP_OUT;
        end
      end
      SP_OUT: begin
        if (osc_tick & (word_reg == 16'(UNLOCK_LEN - 1))) begin
          tp_next = SP_IDLE; // see RQ24
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= sperr_pkg::CTRL_RESET; // see RQ19
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0;
    end else begin
      ack_reg <= bus_req;
      if (bus_req) begin
        rdat_reg <= rd_word;
      end
      if (ctrl_wr) begin
        ctrl_reg <= wb_dat_i[2:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_reg <= 1'b0;
      seen_reg <= 3'h0;
      gap_reg <= 16'h0;
    end else begin
      gap_reg <= (pre_b_i | pre_m_i | pre_w_i | ~lock_reg) ? 16'h0 : gap_reg + 16'h1;
      if (lose_lock) begin
        lock_reg <= 1'b0;
        seen_reg <= 3'h0;
      end else if (!lock_reg) begin
        seen_reg <= seen_reg | {pre_w_i, pre_m_i, pre_b_i};
        if (all_seen) begin
          lock_reg <= 1'b1; // see RQ15
        end
      end
    end
  end

  // hold counts frames; any cause reloads it so the hold runs from recovery
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_reg <= 16'h0;
      err_reg <= 1'b1;
      short_reg <= 1'b0;
      outen_reg <= 1'b0;
      run_reg <= 4'h0;
    end else begin
      run_reg <= run_next;
      if (cause) begin
        hold_reg <= 16'(HOLD_LEN); // see RQ6
      end else if (frame_clock_i && hold_reg != 16'h0) begin
        hold_reg <= hold_reg - 16'h1; // see RQ24
      end
      if (par_err & npcm_lat & ~run_long) begin
        short_reg <= 1'b1; // see RQ7
      end else if (frame_clock_i) begin
        short_reg <= 1'b0;
      end
      if (frame_clock_i) begin
        err_reg <= err_next; // see RQ4
        outen_reg <= ~err_reg & ~hard_err; // see RQ16
      end else if (hard_err) begin
        outen_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      csfs_reg <= 4'h0;
      fsprev_reg <= 4'h0;
      fsout_reg <= 4'h0;
      npcm_reg <= 1'b0;
      npcm_lat <= 1'b0;
      emph_reg <= 1'b0;
      subq_reg <= 1'b0;
    end else begin
      if (cs_block_i) begin
        csfs_reg <= cs_fs_i;
        npcm_reg <= cs_npcm_i; // see RQ17
        emph_reg <= cs_emph_i; // see RQ18
      end
      // latch only while parity is clean so a run keeps the earlier verdict
      if (cs_block_i && run_reg == 4'h0) begin
        npcm_lat <= cs_npcm_i; // see RQ11
      end
      if (fs_valid_i) begin
        fsprev_reg <= fs_calc_i;
      end
      fsout_reg <= hard_err ? 4'h0 : fsprev_reg; // see RQ14
      subq_reg <= ~hard_err; // see RQ14
    end
  end

  always_ff @(posedge clk_i) begin
    if (sub_valid_i & ~par_err) begin
      cs_mem[cs_idx_i] <= cs_in;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_l <= 24'h0;
      prev_r <= 24'h0;
      aud_reg <= 24'h0;
      aval_reg <= 1'b0;
      aright_reg <= 1'b0;
      csb_reg <= 1'b0;
    end else begin
      aval_reg <= sub_valid_i;
      if (sub_valid_i) begin
        aud_reg <= aud_next;
        aright_reg <= sub_right_i;
        csb_reg <= cs_next;
        if (sub_right_i) begin
          prev_r <= aud_next;
        end else begin
          prev_l <= aud_next;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tp_reg <= SP_IDLE;
      div_reg <= 16'h0;
      word_reg <= 16'h0;
      upo_reg <= 1'b1;
    end else begin
      tp_reg <= tp_next;
      div_reg <= osc_tick ? 16'h0 : div_reg + 16'h1;
      if (tp_reg != SP_OUT) begin
        word_reg <= 16'h0;
      end else if (osc_tick) begin
        word_reg <= word_reg + 16'h1;
      end
      // register mode follows the bit; transition mode is low in a pulse
      upo_reg <= sel_tp ? ~(tp_next == SP_IN || tp_next == SP_OUT)
                        : ctrl_reg[sperr_pkg::CTRL_VAL]; // see RQ20
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign error_o = err_reg;
  assign locked_o = lock_reg;
  assign audio_data_out_o = aud_reg;
  assign audio_valid_o = aval_reg;
  assign audio_right_o = aright_reg;
  assign cs_bit_o = csb_reg;
  assign fs_out_o = fsout_reg;
  assign subq_en_o = subq_reg;
  assign npcm_o = npcm_reg;
  assign emph_o = emph_reg;
  assign osc_src_o = err_reg; // see RQ23
  assign user_port_out_o = upo_reg;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_err_frame_sync: assert property (!frame_clock_i |=> $stable(err_reg)) // see RQ4
    else $error("error flag changed off a frame tick");
  a_err_on_unlock: assert property (frame_clock_i && !lock_reg |=> err_reg) // see RQ1
    else $error("error low while unlocked");
  a_long_run_err: assert property (frame_clock_i && run_long |=> err_reg) // see RQ6
    else $error("long parity run without error");
  a_run_clear: assert property (sub_valid_i && !par_err |=> run_reg == 4'h0) // see RQ25
    else $error("parity run not cleared");
  a_hold_reload: assert property (cs_chg |=> hold_reg == 16'(HOLD_LEN)) // see RQ8
    else $error("status change did not restart hold");
  a_mute_unlock: assert property (sub_valid_i && !lock_reg |=> aud_reg == 24'h0) // see RQ12
    else $error("audio not muted while unlocked");
  a_repeat_prev: assert property (sub_valid_i && !hard_err && outen_reg && repeat_pcm
    && !sub_right_i |=> aud_reg == $past(prev_l)) // see RQ10
    else $error("pcm error sample not repeated");
  a_fs_forced: assert property (hard_err |=> fsout_reg == 4'h0 && !subq_reg) // see RQ14
    else $error("fs or subcode not forced low");
  a_user_reg: assert property (!sel_tp |=> upo_reg == $past(ctrl_reg[1])) // see RQ19
    else $error("user pin not following register bit");
  a_unlock_pulse: assert property (sel_tp && err_rise && tp_reg == SP_IDLE
    |=> ##1 !upo_reg) // see RQ22
    else $error("unlock pulse missing");
endmodule
`default_nettype wire

// ---- test/sperr_tx_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module sperr_tx_model (
  input wire logic clk_i, // bench clock
  input wire logic link_on_i, // stream present
  output logic frame_clock_o, // frame tick
  output logic pre_b_o, // preamble b
  output logic pre_m_o, // preamble m
  output logic pre_w_o, // preamble w
  output logic bmc_viol_o, // violation pulse
  output logic sub_valid_o, // subframe strobe
  output logic sub_right_o, // channel
  output logic sub_parity_o, // parity bit
  output logic [27:0] sub_bits_o // payload
);
  logic [2:0] cnt_reg;
  initial begin
    cnt_reg = 3'h0;
    {frame_clock_o, pre_b_o, pre_m_o, pre_w_o, bmc_viol_o} = 5'h00;
    {sub_valid_o, sub_right_o, sub_parity_o} = 3'h0;
    sub_bits_o = 28'h0000000;
  end
  // one frame every 8 cycles keeps the preamble gap far below the timeout
  always @(posedge clk_i) begin
    cnt_reg <= cnt_reg + 3'h1;
    frame_clock_o <= (cnt_reg == 3'h7);
    pre_b_o <= link_on_i && (cnt_reg == 3'h7);
    pre_m_o <= link_on_i && (cnt_reg == 3'h7);
    pre_w_o <= link_on_i && (cnt_reg == 3'h7);
  end
  task automatic sub(input logic right, input logic [23:0] smp, input logic bad);
    @(posedge clk_i);
    sub_valid_o <= 1'b1;
    sub_right_o <= right;
    sub_bits_o <= {4'h0, smp};
    sub_parity_o <= (^smp) ^ bad;
    @(posedge clk_i);
    sub_valid_o <= 1'b0;
    // released lines show the inverse so stale data is never mistaken
    sub_bits_o <= ~{4'h0, smp};
    sub_parity_o <= ~((^smp) ^ bad);
  endtask
  task automatic viol();
    @(posedge clk_i);
    bmc_viol_o <= 1'b1;
    @(posedge clk_i);
    bmc_viol_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- test/sperr_top_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module sperr_top_tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, link_on = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0, cs_fs_i = 4'h0, fs_calc_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, cs_block_i = 1'b0;
  logic cs_npcm_i = 1'b0, cs_emph_i = 1'b0, fs_valid_i = 1'b0, fs_in_range_i = 1'b1;
  wire logic [31:0] wb_dat_o;
  wire logic [27:0] sub_bits;
  wire logic [23:0] audio;
  wire logic [3:0] fs_out_o;
  wire logic wb_ack_o, fck, pb, pm, pw, viol, sv, sr, sp, error_o, locked_o;
  wire logic subq_en_o, npcm_o, emph_o, osc_src_o, user_o, aval, aright;
  int fails = 0, compares = 0;
  logic [31:0] r;
  always #5 clk_i = ~clk_i;
  sperr_tx_model sperr_tx_model_inst (.clk_i(clk_i), .link_on_i(link_on),
    .frame_clock_o(fck), .pre_b_o(pb), .pre_m_o(pm), .pre_w_o(pw), .bmc_viol_o(viol),
    .sub_valid_o(sv), .sub_right_o(sr), .sub_parity_o(sp), .sub_bits_o(sub_bits));
  sperr_top #(.HOLD_LEN(4), .OSC_DIV(4), .UNLOCK_LEN(2), .PRE_GAP(64)) sperr_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frame_clock_i(fck), .bmc_viol_i(viol),
    .pre_b_i(pb), .pre_m_i(pm), .pre_w_i(pw), .sub_valid_i(sv), .sub_right_i(sr),
    .sub_parity_i(sp), .sub_bits_i(sub_bits), .cs_idx_i(8'h00), .cs_block_i(cs_block_i),
    .cs_fs_i(cs_fs_i), .cs_npcm_i(cs_npcm_i), .cs_emph_i(cs_emph_i), .fs_valid_i(fs_valid_i),
    .fs_calc_i(fs_calc_i), .fs_in_range_i(fs_in_range_i), .error_o(error_o),
    .locked_o(locked_o), .audio_data_out_o(audio), .audio_valid_o(aval), .audio_right_o(aright),
    .cs_bit_o(), .fs_out_o(fs_out_o), .subq_en_o(subq_en_o), .npcm_o(npcm_o),
    .emph_o(emph_o), .osc_src_o(osc_src_o), .user_port_out_o(user_o));
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, we, a, d, 4'hf};
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    chk("ack", wb_ack_o, 1);
    r = wb_dat_o;
    // hold the request up to the edge that samples ack high
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    #1;
  endtask
  task automatic ftk();
    do begin
      @(posedge clk_i);
      #1;
    end while (fck !== 1'b1);
    @(posedge clk_i);
    #1;
  endtask
  task automatic wait_err(input logic v);
    logic p;
    for (int n = 0; n < 400; n++) begin
      p = fck;
      @(posedge clk_i);
      #1;
      if (error_o === v) break;
    end
    chk("err move tick", p, 1);
    chk("error", error_o, v);
  endtask
  task automatic blk(input logic [3:0] fs, input logic np, input logic em);
    @(posedge clk_i);
    {cs_block_i, cs_fs_i, cs_npcm_i, cs_emph_i} <= {1'b1, fs, np, em};
    @(posedge clk_i);
    cs_block_i <= 1'b0;
    #1;
  endtask
  task automatic fsv(input logic [3:0] c, input logic ok);
    @(posedge clk_i);
    {fs_valid_i, fs_calc_i, fs_in_range_i} <= {1'b1, c, ok};
    @(posedge clk_i);
    fs_valid_i <= 1'b0;
    ftk();
  endtask
  task automatic t_reset();
    chk("error", error_o, 1);
    chk("locked", locked_o, 0);
    chk("user", user_o, 1);
    wb(1'b0, sperr_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl", r[2:0], sperr_pkg::CTRL_RESET);
    wb(1'b0, 4'hc, 32'h0);
    chk("unmapped", r, 32'h0);
  endtask
  task automatic t_lock();
    int n;
    @(posedge clk_i);
    link_on <= 1'b1;
    for (n = 0; n < 100 && locked_o !== 1'b1; n++) @(posedge clk_i);
    #1;
    chk("locked", locked_o, 1);
    ftk();
    chk("hold", error_o, 1);
    sperr_tx_model_inst.sub(1'b0, 24'h5a5a5a, 1'b0);
    #1;
    chk("muted", audio, 24'h0);
    wait_err(1'b0);
    chk("osc src", osc_src_o, 0);
    ftk();
    sperr_tx_model_inst.sub(1'b0, 24'h123456, 1'b0);
    #1;
    chk("audio", audio, 24'h123456);
  endtask
  task automatic t_pcm();
    sperr_tx_model_inst.sub(1'b1, 24'h222222, 1'b0);
    sperr_tx_model_inst.sub(1'b0, 24'h333333, 1'b1);
    #1;
    chk("repeat l", audio, 24'h123456);
    sperr_tx_model_inst.sub(1'b1, 24'h444444, 1'b1);
    #1;
    chk("repeat r", audio, 24'h222222);
    chk("valid", aval, 1);
    chk("right", aright, 1);
    wb(1'b0, sperr_pkg::ADDR_STAT, 32'h0);
    chk("run", r[11:8], 4'h2);
    ftk();
    chk("pcm no err", error_o, 0);
    sperr_tx_model_inst.sub(1'b0, 24'h555555, 1'b0);
    wb(1'b0, sperr_pkg::ADDR_STAT, 32'h0);
    chk("run clr", r[11:8], 4'h0);
  endtask
  task automatic t_long();
    for (int i = 0; i < 9; i++) sperr_tx_model_inst.sub(i[0], 24'h0abcde, 1'b1);
    #1;
    chk("long mute", audio, 24'h0);
    ftk();
    chk("long err", error_o, 1);
    chk("fs low", fs_out_o, 4'h0);
    chk("subq low", subq_en_o, 0);
    sperr_tx_model_inst.sub(1'b0, 24'h000001, 1'b0);
    wait_err(1'b0);
  endtask
  task automatic t_npcm();
    blk(4'h0, 1'b1, 1'b1);
    chk("npcm pin", npcm_o, 1);
    chk("emph pin", emph_o, 1);
    ftk();
    sperr_tx_model_inst.sub(1'b0, 24'h777777, 1'b1);
    #1;
    chk("npcm pass", audio, 24'h777777);
    ftk();
    chk("npcm err", error_o, 1);
    sperr_tx_model_inst.sub(1'b0, 24'h000002, 1'b0);
    wait_err(1'b0);
    blk(4'h0, 1'b0, 1'b0);
    chk("pcm pin", npcm_o, 0);
    blk(4'h3, 1'b0, 1'b0);
    ftk();
    chk("fs bits", error_o, 1);
    wait_err(1'b0);
  endtask
  task automatic t_range();
    wb(1'b1, sperr_pkg::ADDR_CTRL, 32'h4);
    chk("user reg", user_o, 0);
    fsv(4'h5, 1'b1);
    chk("fs change", error_o, 1);
    wait_err(1'b0);
    fsv(4'h5, 1'b1);
    chk("fs same", error_o, 0);
    fsv(4'h5, 1'b0);
    chk("range", error_o, 1);
    wait_err(1'b0);
  endtask
  task automatic t_user();
    int n;
    wb(1'b1, sperr_pkg::ADDR_CTRL, 32'h1);
    chk("idle high", user_o, 1);
    sperr_tx_model_inst.viol();
    wait_err(1'b1);
    repeat (2) @(posedge clk_i);
    #1;
    chk("unlock low", user_o, 0);
    for (n = 0; n < 40 && user_o !== 1'b1; n++) begin
      @(posedge clk_i);
      #1;
    end
    for (n = 0; n < 40 && user_o !== 1'b0; n++) begin
      @(posedge clk_i);
      #1;
    end
    chk("lockin low", user_o, 0);
    chk("lockin err", error_o, 1);
    wait_err(1'b0);
    repeat (2) @(posedge clk_i);
    #1;
    chk("lockin end", user_o, 1);
  endtask
  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #300000;
    fails++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    t_reset();
    t_lock();
    t_pcm();
    t_long();
    t_npcm();
    t_range();
    t_user();
    test_done();
  end
endmodule
`default_nettype wire
